// ---- core/pca_pkg.sv ----
/*
 * Shared constants, the decoded command type and the decode helpers of
 * the command/address capture port.
 * Assumes a 48-bit command/address word packed most significant first.
 */
package pca_pkg;

	// ------------------------------------------------------------------
	// Command/address word layout
	// ------------------------------------------------------------------
	localparam int CA_W         = 48;
	localparam int CA_RW_BIT    = 47;
	localparam int CA_SPACE_BIT = 46;
	localparam int CA_BURST_BIT = 45;
	localparam int CA_ROW_HI    = 44;
	localparam int CA_ROW_LO    = 16;
	localparam int CA_COL_HI    = 2;
	localparam int CA_COL_LO    = 0;
	localparam int ROW_W        = CA_ROW_HI - CA_ROW_LO + 1;
	localparam int COL_W        = CA_COL_HI - CA_COL_LO + 1;

	// ------------------------------------------------------------------
	// Edge counts and reset values
	// ------------------------------------------------------------------
	localparam logic [1:0] EDGES_PER_PHASE = 2'h3;
	localparam logic [1:0] ROW_FALL_IDX    = 2'h1;
	localparam logic [1:0] CA_FALL_IDX     = 2'h2;
	localparam logic [1:0] CNT_RST         = 2'h0;
	localparam logic [7:0] BYTE_RST        = 8'h00;
	localparam logic [15:0] WORD_RST       = 16'h0000;
	localparam logic       CS_IDLE         = 1'b1;
	localparam logic [2:0] CORE_SYNC_RST   = 3'h4;

	typedef struct packed {
		logic             is_read;
		logic             reg_space;
		logic             linear;
		logic [ROW_W-1:0] row_upper;
		logic [COL_W-1:0] col;
	} pca_cmd_t;

	localparam pca_cmd_t CMD_RST = '0;

	// Bits 15..3 are reserved and never looked at.
	function automatic pca_cmd_t pca_decode(input logic [CA_W-1:0] w);
		pca_cmd_t c;
		c.is_read   = w[CA_RW_BIT];
		c.reg_space = w[CA_SPACE_BIT];
		c.linear    = w[CA_BURST_BIT];
		c.row_upper = w[CA_ROW_HI:CA_ROW_LO];
		c.col       = w[CA_COL_HI:CA_COL_LO];
		return c;
	endfunction

	function automatic logic [ROW_W-1:0] pca_next_half(
		input logic [ROW_W-1:0] r);
		return ROW_W'(r + 1'b1);
	endfunction

endpackage

// ---- core/pca_sync2.sv ----
/*
 * Two flip-flop level synchroniser with a chosen reset value.
 * Assumes each bit is a level that holds long enough to be seen.
 */
`timescale 1ns/1ns
module pca_sync2 #(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pca_sync_t;

	pca_sync_t s_q;
	pca_sync_t s_d;

	always_comb begin
		s_d.meta   = d;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= {RST, RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.stable;

endmodule // pca_sync2

// ---- core/pca_ddr_capture.sv ----
/*
 * Link-clock half of the port: catches six command/address bytes on
 * both edges and holds the read word that the pins present.
 * Assumes link_rst_b is low whenever select is high, so every frame
 * starts from a clean state without needing clock edges.
 */
`timescale 1ns/1ns
module pca_ddr_capture
	import pca_pkg::*;
(
	input  wire logic            ck,
	input  wire logic            link_rst_b,
	input  wire logic [7:0]      dq_i,
	input  wire logic            rd_tgl_s,
	input  wire logic [15:0]     rd_word_i,
	output logic      [CA_W-1:0] ca_word_o,
	output logic                 row_done_o,
	output logic                 ca_done_o,
	output logic      [15:0]     rd_hold_o
);

	typedef struct packed {
		logic [1:0]  cnt;
		logic [7:0]  b0;
		logic [7:0]  b2;
		logic [7:0]  b4;
		logic        tgl_seen;
		logic [15:0] hold;
	} pca_rise_t;

	typedef struct packed {
		logic [1:0] cnt;
		logic [7:0] b1;
		logic [7:0] b3;
		logic [7:0] b5;
		logic       row_done;
		logic       ca_done;
	} pca_fall_t;

	pca_rise_t r_q;
	pca_rise_t r_d;
	pca_fall_t f_q;
	pca_fall_t f_d;

	// ------------------------------------------------------------------
	// Rising edges: bytes 0, 2 and 4, then read word hand-over
	// ------------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		// (RL10) even bytes on rises
		if (r_q.cnt != EDGES_PER_PHASE) begin
			r_d.cnt = 2'(r_q.cnt + 1'b1);
			case (r_q.cnt)
				2'h0: r_d.b0 = dq_i;
				2'h1: r_d.b2 = dq_i;
				default: r_d.b4 = dq_i;
			endcase
		end
		// The core changes its word only on the cycle that it toggles, and the toggle is synchronised first, so the word is stable.
		if (rd_tgl_s != r_q.tgl_seen) begin
			r_d.tgl_seen = rd_tgl_s;
			r_d.hold     = rd_word_i;
		end
	end

	always_ff @(posedge ck or negedge link_rst_b) begin
		if (!link_rst_b) begin
			r_q <= '{cnt: CNT_RST, b0: BYTE_RST, b2: BYTE_RST,
				b4: BYTE_RST, tgl_seen: 1'b0, hold: WORD_RST};
		end else begin
			r_q <= r_d;
		end
	end

	// ------------------------------------------------------------------
	// Falling edges: bytes 1, 3 and 5 with progress flags
	// ------------------------------------------------------------------
	always_comb begin
		f_d = f_q;
		// (RL10) odd bytes on falls
		if (f_q.cnt != EDGES_PER_PHASE) begin
			f_d.cnt = 2'(f_q.cnt + 1'b1);
			case (f_q.cnt)
				2'h0: f_d.b1 = dq_i;
				2'h1: f_d.b3 = dq_i;
				default: f_d.b5 = dq_i;
			endcase
			// (RL20) row bits complete
			if (f_q.cnt == ROW_FALL_IDX) begin
				f_d.row_done = 1'b1;
			end
			if (f_q.cnt == CA_FALL_IDX) begin
				f_d.ca_done = 1'b1;
			end
		end
	end

	always_ff @(negedge ck or negedge link_rst_b) begin
		if (!link_rst_b) begin
			f_q <= '{cnt: CNT_RST, b1: BYTE_RST, b3: BYTE_RST,
				b5: BYTE_RST, row_done: 1'b0, ca_done: 1'b0};
		end else begin
			f_q <= f_d;
		end
	end

	// (RL11) first byte lands highest
	assign ca_word_o  = {r_q.b0, f_q.b1, r_q.b2, f_q.b3, r_q.b4, f_q.b5};
	assign row_done_o = f_q.row_done;
	assign ca_done_o  = f_q.ca_done;
	assign rd_hold_o  = r_q.hold;

endmodule // pca_ddr_capture

// ---- core/pca_port.sv ----
/*
 * Slave command/address port of a self-refreshing pseudo-static DRAM:
 * pin-side capture on the link clock, decode and frame tracking on
 * core_clk, and the strobe/mask and data pin drivers.
 * Assumes the refresh engine supplies the latency request and the array
 * supplies read words through the load strobe.
 */
// Rules from the document
// (RL1) Select fall opens, rise closes transactions.
// (RL2) Host gives each slave its own select.
// (RL3) Sample on clock; complement unused single-ended.
// (RL4) Nothing depends on a free-running link clock.
// (RL5) Strobe shows extra latency during command phase.
// (RL6) Strobe is edge-aligned read data strobe.
// (RL7) Host drives strobe as write mask input.
// (RL8) Reset floats strobe and data, returns standby.
// (RL9) Host lowers select only with clock idle.
// (RL10) Six command bytes over first six edges.
// (RL11) Bytes most significant first, bit7 on line7.
// (RL12) Bit 47 set means read, clear write.
// (RL13) Bit 46 picks memory or register space.
// (RL14) Bit 45 picks wrapped or linear burst.
// (RL15) Bits 44..16 give word address 31..3.
// (RL16) Bits 15..3 reserved and ignored.
// (RL17) Bits 2..0 give starting word.
// (RL18) Upper column picks an eight-word half-page.
// (RL19) Flag bursts that will cross a page.
// (RL20) Access timing starts once row bits arrive.
// (RL21) Linear reads prefetch the next half-page.
// (RL22) Host centres command bytes on clock edges.
// (RL23) Write mask high skips byte, low writes; strobe_mask_i is not used.
// (RL24) Read byte A while strobe high, B low.
// (RL25) Early select rise abandons without side effects; a row_valid_o pulse already sent after four edges is not withdrawn.
`timescale 1ns/1ns
module pca_port
	import pca_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic             ck,
	input  wire logic             clock_complement,
	input  wire logic             cs_n,
	input  wire logic [7:0]       dq_i,
	output logic      [7:0]       dq_o,
	output logic                  dq_oe,
	input  wire logic             strobe_mask_i,
	output logic                  strobe_mask_o,
	output logic                  strobe_mask_oe,
	input  wire logic             need_latency_i,
	input  wire logic             rd_phase_i,
	input  wire logic [15:0]      rd_word_i,
	input  wire logic             rd_load_i,
	output pca_cmd_t              cmd_o,
	output logic                  cmd_valid_o,
	output logic      [ROW_W-1:0] row_addr_o,
	output logic                  row_valid_o,
	output logic      [ROW_W-1:0] prefetch_addr_o,
	output logic                  prefetch_valid_o,
	output logic                  page_cross_o,
	output logic                  xact_open_o,
	output logic                  xact_close_o,
	output logic                  abort_o,
	output logic                  busy_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_OPEN,
		ST_DECODED
	} pca_state_t;

	typedef struct packed {
		pca_state_t       st;
		logic             cs_prev;
		logic             row_prev;
		logic             ca_prev;
		logic             lat;
		logic             rd_tgl;
		logic [15:0]      rd_word;
		logic [CA_W-1:0]  word;
		pca_cmd_t         cmd;
		logic             cmd_v;
		logic [ROW_W-1:0] row_addr;
		logic             row_v;
		logic [ROW_W-1:0] pf_addr;
		logic             pf_v;
		logic             page_x;
		logic             open_p;
		logic             close_p;
		logic             abort_p;
	} pca_core_t;

	pca_core_t       s_q;
	pca_core_t       s_d;
	logic            link_rst_b;
	logic [CA_W-1:0] ca_word;
	logic            row_done;
	logic            ca_done;
	logic [15:0]     rd_hold;
	logic [2:0]      core_sync;
	logic [1:0]      link_sync;
	logic            cs_s;
	logic            row_s;
	logic            ca_s;
	logic            ca_phase;
	logic            read_drive;

	// ------------------------------------------------------------------
	// Link-clock side
	// ------------------------------------------------------------------
	// (RL4) frame ended by select itself
	assign link_rst_b = rst_b & ~cs_n;

	pca_sync2 #(
		.W   (2),
		.RST (2'h0)
	) u_link_sync (
		.clk   (ck),
		.rst_b (link_rst_b),
		.d     ({s_q.rd_tgl, rd_phase_i}),
		.q     (link_sync)
	);

	// (RL3) edges of the true clock only
	pca_ddr_capture u_capture (
		.ck         (ck),
		.link_rst_b (link_rst_b),
		.dq_i       (dq_i),
		.rd_tgl_s   (link_sync[1]),
		.rd_word_i  (s_q.rd_word),
		.ca_word_o  (ca_word),
		.row_done_o (row_done),
		.ca_done_o  (ca_done),
		.rd_hold_o  (rd_hold)
	);

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	assign ca_phase   = ~cs_n & ~ca_done;
	// (RL7) write data leaves strobe as input
	assign read_drive = ~cs_n & ca_done & ca_word[CA_RW_BIT] & link_sync[0];

	// (RL8) reset floats both pins
	assign strobe_mask_oe = rst_b & (ca_phase | read_drive);
	assign dq_oe          = rst_b & read_drive;
	// (RL5) latency level in command phase
	// (RL6) read strobe follows clock
	assign strobe_mask_o  = ca_phase ? s_q.lat : ck;
	// (RL24) byte A while strobe high
	assign dq_o           = ck ? rd_hold[15:8] : rd_hold[7:0];

	// ------------------------------------------------------------------
	// Core-clock side
	// ------------------------------------------------------------------
	pca_sync2 #(
		.W   (3),
		.RST (CORE_SYNC_RST)
	) u_core_sync (
		.clk   (core_clk),
		.rst_b (rst_b),
		.d     ({cs_n, row_done, ca_done}),
		.q     (core_sync)
	);

	assign cs_s  = core_sync[2];
	assign row_s = core_sync[1];
	assign ca_s  = core_sync[0];

	always_comb begin
		s_d          = s_q;
		s_d.cs_prev  = cs_s;
		s_d.row_prev = row_s;
		s_d.ca_prev  = ca_s;
		s_d.cmd_v    = 1'b0;
		s_d.row_v    = 1'b0;
		s_d.pf_v     = 1'b0;
		s_d.open_p   = 1'b0;
		s_d.close_p  = 1'b0;
		s_d.abort_p  = 1'b0;
		if (rd_load_i) begin
			s_d.rd_word = rd_word_i;
			s_d.rd_tgl  = ~s_q.rd_tgl;
		end
		case (s_q.st)
			ST_IDLE: begin
				s_d.lat = need_latency_i;
				// (RL1) select fall opens
				if (s_q.cs_prev && !cs_s) begin
					s_d.st     = ST_OPEN;
					s_d.open_p = 1'b1;
					s_d.rd_tgl = 1'b0;
				end
			end
			ST_OPEN: begin
				// (RL20) start access timing
				if (row_s && !s_q.row_prev) begin
					// (RL15) (RL18) half-page row address
					s_d.row_addr = ca_word[CA_ROW_HI:CA_ROW_LO];
					s_d.row_v    = 1'b1;
				end
				// (RL25) abandon partial command
				if (cs_s) begin
					s_d.st      = ST_IDLE;
					s_d.close_p = 1'b1;
					s_d.abort_p = 1'b1;
				end else if (ca_s && !s_q.ca_prev) begin
					// (RL12) (RL13) (RL14) (RL16) (RL17) decode fields
					s_d.st   = ST_DECODED;
					s_d.word = ca_word;
					s_d.cmd  = pca_decode(ca_word);
					s_d.cmd_v = 1'b1;
					// (RL21) prefetch next half-page
					s_d.pf_addr = pca_next_half(s_d.cmd.row_upper);
					s_d.pf_v    = s_d.cmd.linear & s_d.cmd.is_read;
					// (RL19) odd half-page leads into next page
					s_d.page_x  = s_d.cmd.linear & s_d.cmd.row_upper[0];
				end
			end
			default: begin
				// (RL1) select rise closes
				if (cs_s) begin
					s_d.st      = ST_IDLE;
					s_d.close_p = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{st: ST_IDLE, cs_prev: CS_IDLE, row_prev: 1'b0,
				ca_prev: 1'b0, lat: 1'b0, rd_tgl: 1'b0,
				rd_word: WORD_RST, word: '0, cmd: CMD_RST,
				cmd_v: 1'b0, row_addr: '0, row_v: 1'b0,
				pf_addr: '0, pf_v: 1'b0, page_x: 1'b0,
				open_p: 1'b0, close_p: 1'b0, abort_p: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_o            = s_q.cmd;
	assign cmd_valid_o      = s_q.cmd_v;
	assign row_addr_o       = s_q.row_addr;
	assign row_valid_o      = s_q.row_v;
	assign prefetch_addr_o  = s_q.pf_addr;
	assign prefetch_valid_o = s_q.pf_v;
	assign page_cross_o     = s_q.page_x;
	assign xact_open_o      = s_q.open_p;
	assign xact_close_o     = s_q.close_p;
	assign abort_o          = s_q.abort_p;
	assign busy_o           = (s_q.st != ST_IDLE);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	property p_open;
		(s_q.cs_prev && !cs_s && s_q.st == ST_IDLE) |=> xact_open_o ##1
			!xact_open_o;
	endproperty
	a_open: assert property (p_open) else $error("open pulse missing"); // RL1

	property p_close;
		(s_q.st != ST_IDLE && cs_s) |=> xact_close_o && !busy_o;
	endproperty
	a_close: assert property (p_close) else $error("close missing"); // RL1

	property p_abort;
		abort_o |-> $past(s_q.st) == ST_OPEN && !cmd_valid_o &&
			!prefetch_valid_o;
	endproperty
	a_abort: assert property (p_abort) else $error("bad abort"); // RL25

	property p_dir;
		cmd_valid_o |-> cmd_o.is_read == s_q.word[CA_RW_BIT] &&
			cmd_o.reg_space == s_q.word[CA_SPACE_BIT];
	endproperty
	a_dir: assert property (p_dir) else $error("direction or space"); // RL12

	property p_burst;
		cmd_valid_o |-> cmd_o.linear == s_q.word[CA_BURST_BIT];
	endproperty
	a_burst: assert property (p_burst) else $error("burst type"); // RL14

	property p_addr;
		cmd_valid_o |-> cmd_o.row_upper == s_q.word[CA_ROW_HI:CA_ROW_LO] &&
			cmd_o.col == s_q.word[CA_COL_HI:CA_COL_LO];
	endproperty
	a_addr: assert property (p_addr) else $error("address fields"); // RL15

	property p_prefetch;
		prefetch_valid_o |-> cmd_valid_o && cmd_o.linear && cmd_o.is_read &&
			prefetch_addr_o == ROW_W'(cmd_o.row_upper + 1'b1);
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("prefetch"); // RL21

	property p_row_first;
		cmd_valid_o |-> !row_valid_o && $past(s_q.st) == ST_OPEN;
	endproperty
	a_row_first: assert property (p_row_first) else $error("row order"); // RL20

	property p_reset_float;
		@(posedge core_clk) disable iff (1'b0)
			!rst_b |-> !dq_oe && !strobe_mask_oe;
	endproperty
	a_reset_float: assert property (p_reset_float) else $error("pins driven"); // RL8

	property p_float_idle;
		cs_n |-> !dq_oe && !strobe_mask_oe;
	endproperty
	a_float_idle: assert property (p_float_idle) else $error("idle drive"); // RL5

	c_read: cover property (cmd_valid_o && cmd_o.is_read);
	c_write: cover property (cmd_valid_o && !cmd_o.is_read);
	c_abort: cover property (abort_o);
	c_prefetch: cover property (prefetch_valid_o ##[1:50] xact_close_o);

endmodule // pca_port

// ---- verification/pca_host_model.sv ----
/*
 * Host side model: drives select, the link clock and the data lines.
 * Assumes the bench resolves the data wire from both drivers.
 */
`timescale 1ns/1ns
module pca_host_model (
	output logic             ck,
	output logic             clock_complement,
	output logic             cs_n,
	output logic       [7:0] dq_drv,
	input  wire logic  [7:0] dev_dq,
	input  wire logic        dev_dq_oe,
	input  wire logic        dev_sm,
	input  wire logic        dev_sm_oe
);
	assign clock_complement = ~ck;
	initial begin
		ck     = 1'b0;
		cs_n   = 1'b1;
		dq_drv = 8'h00;
	end
	task automatic frame(input logic [47:0] w, input int ne,
		output logic [1:0] sm);
		sm   = 2'h0;
		cs_n = 1'b0;
		#6;
		for (int i = 0; i < ne; i++) begin
			dq_drv = w[47-8*i -: 8];
			#3;
			if (i == 1)
				sm = {dev_sm_oe, dev_sm};
			ck = ~ck;
			#3;
		end
		dq_drv = ~dq_drv;
	endtask
	task automatic close();
		#3;
		cs_n = 1'b1;
	endtask
	task automatic rd_cycle(output logic [7:0] a, output logic [7:0] b,
		output logic [2:0] s);
		#3;
		ck = 1'b1;
		#3;
		a    = dev_dq;
		s[1] = dev_sm;
		s[2] = dev_dq_oe;
		#3;
		ck = 1'b0;
		#3;
		b    = dev_dq;
		s[0] = dev_sm;
	endtask
endmodule // pca_host_model

// ---- verification/pca_port_tb.sv ----
/*
 * Self-checking bench of the command/address port.
 * Assumes the host model and the design package.
 */
`timescale 1ns/1ns
module pca_port_tb import pca_pkg::*; ;
	logic             core_clk = 1'b0;
	logic             rst_b;
	logic             ck;
	logic             clock_complement;
	logic             cs_n;
	logic [7:0]       dq_i;
	logic [7:0]       dq_o;
	logic [7:0]       dq_drv;
	logic             dq_oe;
	logic             strobe_mask_i;
	logic             strobe_mask_o;
	logic             strobe_mask_oe;
	logic             need_latency_i;
	logic             rd_phase_i;
	logic [15:0]      rd_word_i;
	logic             rd_load_i;
	pca_cmd_t         cmd_o;
	pca_cmd_t         cap_cmd;
	logic             cmd_valid_o;
	logic [ROW_W-1:0] row_addr_o;
	logic [ROW_W-1:0] cap_row;
	logic             row_valid_o;
	logic [ROW_W-1:0] prefetch_addr_o;
	logic [ROW_W-1:0] cap_pref;
	logic             prefetch_valid_o;
	logic             page_cross_o;
	logic             xact_open_o;
	logic             xact_close_o;
	logic             abort_o;
	logic             busy_o;
	int               mismatches = 0;
	int               total_checks = 0;
	int               cycles = 0;
	int               n_open, n_close, n_abort, n_cmd, n_row, n_pref;
	logic [47:0]      w;

	always #4 core_clk = ~core_clk;
	assign dq_i = dq_oe ? dq_o : dq_drv;
	assign strobe_mask_i = strobe_mask_oe ? strobe_mask_o : ~strobe_mask_o;

	pca_port u_dut (.core_clk(core_clk), .rst_b(rst_b), .ck(ck),
		.clock_complement(clock_complement), .cs_n(cs_n), .dq_i(dq_i),
		.dq_o(dq_o), .dq_oe(dq_oe), .strobe_mask_i(strobe_mask_i),
		.strobe_mask_o(strobe_mask_o), .strobe_mask_oe(strobe_mask_oe),
		.need_latency_i(need_latency_i), .rd_phase_i(rd_phase_i),
		.rd_word_i(rd_word_i), .rd_load_i(rd_load_i), .cmd_o(cmd_o),
		.cmd_valid_o(cmd_valid_o), .row_addr_o(row_addr_o),
		.row_valid_o(row_valid_o), .prefetch_addr_o(prefetch_addr_o),
		.prefetch_valid_o(prefetch_valid_o), .page_cross_o(page_cross_o),
		.xact_open_o(xact_open_o), .xact_close_o(xact_close_o),
		.abort_o(abort_o), .busy_o(busy_o));

	pca_host_model host (.ck(ck), .clock_complement(clock_complement),
		.cs_n(cs_n), .dq_drv(dq_drv), .dev_dq(dq_o), .dev_dq_oe(dq_oe),
		.dev_sm(strobe_mask_o), .dev_sm_oe(strobe_mask_oe));

	// ------------------------------------------------------------------
	// Pulse monitor
	// ------------------------------------------------------------------
	// Sampling on the falling edge sees each one-cycle pulse exactly once.
	always @(negedge core_clk) begin
		n_open  += (xact_open_o === 1'b1);
		n_close += (xact_close_o === 1'b1);
		n_abort += (abort_o === 1'b1);
		n_cmd   += (cmd_valid_o === 1'b1);
		n_row   += (row_valid_o === 1'b1);
		n_pref  += (prefetch_valid_o === 1'b1);
		if (cmd_valid_o === 1'b1)
			cap_cmd = cmd_o;
		if (row_valid_o === 1'b1)
			cap_row = row_addr_o;
		if (prefetch_valid_o === 1'b1)
			cap_pref = prefetch_addr_o;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp,
		input string msg);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask

	function automatic pca_cmd_t exp_cmd(input logic [47:0] v);
		pca_cmd_t c;
		c.is_read   = v[47];
		c.reg_space = v[46];
		c.linear    = v[45];
		c.row_upper = v[44:16];
		c.col       = v[2:0];
		return c;
	endfunction

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic do_frame(input logic [47:0] v, input int ne,
		input logic lat, input logic rs);
		logic [1:0] sm;
		logic [7:0] a, b;
		logic [2:0] s;
		logic       full;
		full = (ne == 6);
		@(posedge core_clk);
		#1 need_latency_i = lat;
		{n_open, n_close, n_abort, n_cmd, n_row, n_pref} = '0;
		repeat (3) @(posedge core_clk);
		#1 host.frame(v, ne, sm);
		check(sm, {1'b1, lat}, "latency strobe");
		repeat (8) @(posedge core_clk);
		#1;
		if (full && v[47]) begin
			rd_phase_i = 1'b1;
			rd_word_i  = 16'($urandom);
			rd_load_i  = 1'b1;
			@(posedge core_clk);
			#1 rd_load_i = 1'b0;
			repeat (5) host.rd_cycle(a, b, s);
			check({a, b}, rd_word_i, "read bytes");
			check(s, 3'h6, "read strobe");
		end
		if (full && !v[47])
			check({dq_oe, strobe_mask_oe}, 2'h0, "write input");
		if (rs) begin
			@(posedge core_clk);
			#1 rst_b = 1'b0;
			repeat (2) @(posedge core_clk);
			#1 check({dq_oe, strobe_mask_oe, busy_o}, 3'h0, "reset");
		end
		host.close();
		rd_phase_i = 1'b0;
		@(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge core_clk);
		#1;
		check(n_open, 1, "open");
		if (!rs)
			check(n_close, 1, "close");
		check(busy_o, 1'b0, "busy");
		check(n_abort, !full, "abort");
		check(n_cmd, full, "cmd count");
		check(n_pref, full & v[47] & v[45], "prefetch");
		check(n_row, ne >= 4, "row count");
		if (ne >= 4)
			check(cap_row, v[44:16], "row addr");
		if (full)
			check(cap_cmd, exp_cmd(v), "cmd");
		if (full && !rs)
			check(page_cross_o, v[45] & v[16], "page");
		if (n_pref == 1)
			check(cap_pref, ROW_W'(v[44:16] + 1), "next half");
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		rst_b          = 1'b0;
		need_latency_i = 1'b0;
		rd_phase_i     = 1'b0;
		rd_word_i      = 16'h0000;
		rd_load_i      = 1'b0;
		void'($urandom(32'h89585005));
		repeat (3) @(posedge core_clk);
		#1 check({dq_oe, strobe_mask_oe}, 2'h0, "pins in reset");
		@(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge core_clk);
		do_frame(48'hffff_ffff_ffff, 6, 1'b1, 1'b0);
		do_frame(48'h2000_0001_fff8, 6, 1'b0, 1'b0);
		do_frame(48'h5a5a_a5a5_0007, 2, 1'b1, 1'b0);
		do_frame(48'ha5a5_5a5a_0000, 4, 1'b0, 1'b0);
		for (int i = 0; i < 16; i++) begin
			w = {16'($urandom), $urandom};
			if (i == 15)
				w[47] = 1'b1;
			do_frame(w, 6, 1'($urandom), i == 15);
		end
		summarize();
	end
endmodule // pca_port_tb
